// File: shared/pcoc_params.svh
// Constants for the channel operational control register bank.
// Assumes an APB slave with 16-bit byte addresses and 32-bit data.
`ifndef PCOC_PARAMS_SVH
`define PCOC_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define PCOC_IDX_SYNC     14'h0A20
`define PCOC_IDX_OUT      14'h0A21
`define PCOC_IDX_USER     14'h0A22
`define PCOC_IDX_STATUS   14'h0D22
`define PCOC_IDX_UPDATE   14'h000F

// Sync, calibration and power-down register fields.
`define PCOC_SOFT_SYNC    2
`define PCOC_CALIBRATE    1
`define PCOC_CH_PWDN      0
`define PCOC_SYNC_MASK    8'h07

// Output power control register fields.
`define PCOC_DIS_B        3
`define PCOC_DIS_A        2
`define PCOC_PD_B         1
`define PCOC_PD_A         0
`define PCOC_OUT_MASK     8'h0F

// Reference and user mode register fields.
`define PCOC_REF_HI       6
`define PCOC_REF_LO       5
`define PCOC_SWM_HI       4
`define PCOC_SWM_LO       2
`define PCOC_USER_HOLD    1
`define PCOC_USER_FREE    0
`define PCOC_USER_MASK    8'h7F

// Status and update fields.
`define PCOC_HIST_BIT     0
`define PCOC_UPDATE_BIT   0

`define PCOC_REG_RESET    8'h00
`define PCOC_ZERO_PAD     24'h00_0000

`endif

// File: shared/pcoc_pkg.sv
// Types shared by the channel control bank and its loop mode decoder.
// Assumes the constants header is included by the files that need numbers.
`default_nettype none

package pcoc_pkg;

  typedef enum logic [1:0] {
    PCOC_LOOP_NORMAL   = 2'b00,
    PCOC_LOOP_HOLDOVER = 2'b01,
    PCOC_LOOP_FREERUN  = 2'b11
  } pcoc_loop_t;

endpackage : pcoc_pkg

`default_nettype wire

// File: shared/pcoc_mode_if.sv
// Carries the forcing requests to the loop mode decoder and its answer back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

interface pcoc_mode_if;
  import pcoc_pkg::*;
  logic       holdReq;
  logic       freeReq;
  logic       histAvail;
  pcoc_loop_t mode;

  modport ctrl (output holdReq, output freeReq, output histAvail, input mode);
  modport dec  (input holdReq, input freeReq, input histAvail, output mode);
endinterface : pcoc_mode_if

`default_nettype wire

// File: design/pcoc_loop_mode.sv
// Decides the forced operating mode of the digital loop.
// Assumes requests come from the control registers of the same clock.
`timescale 1ns/1ps
`default_nettype none

module pcoc_loop_mode (
  pcoc_mode_if.dec m
);
  import pcoc_pkg::*;

  // Free run wins over holdover, since it is the stronger forcing request.
  always_comb begin
    // RULE14 forced free run
    if (m.freeReq) begin
      m.mode = PCOC_LOOP_FREERUN;
    // RULE11 forced holdover
    end else if (m.holdReq) begin
      // RULE12 no history, free run
      m.mode = m.histAvail ? PCOC_LOOP_HOLDOVER : PCOC_LOOP_FREERUN;
    end else begin
      m.mode = PCOC_LOOP_NORMAL;
    end
  end
endmodule : pcoc_loop_mode

`default_nettype wire

// File: design/pcoc_channel_ctrl.sv
// Operational control registers of one clock synthesis channel, on APB.
// Assumes a zero-wait APB master and loop status inputs on the same clock.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_params.svh"

// How it works
// RULE1 - Soft sync stalls unmasked outputs, restart on clear
// RULE2 - Calibration starts on update after rising bit
// RULE3 - Software clears calibrate bit before recalibrating
// RULE4 - Power-down bit puts channel in deep sleep
// RULE5 - Disable bit powers down only that driver
// RULE6 - Power-down bit stops that divider and driver
// RULE7 - Manual reference field picks reference A to D
// RULE8 - Mode codes 000 and 001 are automatic
// RULE9 - Codes 010 to 100 select manual reference
// RULE10 - Codes 101 to 111 are reserved
// RULE11 - Holdover bit forces holdover until cleared
// RULE12 - Without history forced holdover becomes free run
// RULE13 - Status bit zero reports history available
// RULE14 - Free run bit forces free run until cleared
// RULE15 - Reserved bits reset and read as zero
module pcoc_channel_ctrl (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  input  wire logic                syncMaskA,
  input  wire logic                syncMaskB,
  input  wire logic                historyAvailable,
  output var  logic                stallA,
  output var  logic                stallB,
  output var  logic                syncRestart,
  output var  logic                calStart,
  output var  logic                deepSleep,
  output var  logic                driverOffA,
  output var  logic                driverOffB,
  output var  logic                dividerOffA,
  output var  logic                dividerOffB,
  output var  logic [1:0]          refSelect,
  output var  logic [2:0]          switchMode,
  output var  pcoc_pkg::pcoc_loop_t loopMode
);
  import pcoc_pkg::*;

  function automatic logic [15:0] byteAddr(input logic [13:0] idx);
    byteAddr = {idx, 2'b00};
  endfunction : byteAddr

  //////////////////////////////////////////////////////////////////////////////

  logic [7:0]  syncReg, syncNext;
  logic [7:0]  outReg, outNext;
  logic [7:0]  userReg, userNext;
  logic        updReg, updNext;
  logic        calArmedReg, calArmedNext;
  logic        calStartReg, calStartNext;
  logic        restartReg, restartNext;
  logic        stallAReg, stallANext;
  logic        stallBReg, stallBNext;
  logic        sleepReg, sleepNext;
  logic        drvAReg, drvANext;
  logic        drvBReg, drvBNext;
  logic        divAReg, divANext;
  logic        divBReg, divBNext;
  logic [1:0]  refReg, refNext;
  logic [2:0]  swmReg, swmNext;
  pcoc_loop_t  loopReg;
  logic [31:0] rdataReg, rdataNext;
  logic        errReg, errNext;
  logic        readyReg;
  logic        wrEn;
  logic        setup;

  pcoc_mode_if modeBus ();

  pcoc_loop_mode u_loop_mode (
    .m (modeBus.dec)
  );

  assign modeBus.holdReq   = userNext[`PCOC_USER_HOLD];
  assign modeBus.freeReq   = userNext[`PCOC_USER_FREE];
  assign modeBus.histAvail = historyAvailable;

  //////////////////////////////////////////////////////////////////////////////

  // Writes land at the access edge; the slave never inserts wait states.
  always_comb begin
    wrEn     = psel && penable && pwrite && readyReg;
    setup    = psel && !penable;
    syncNext = syncReg;
    outNext  = outReg;
    userNext = userReg;
    // RULE15 reserved bits masked
    if (wrEn && paddr == byteAddr(`PCOC_IDX_SYNC)) begin
      syncNext = pwdata[7:0] & `PCOC_SYNC_MASK;
    end
    if (wrEn && paddr == byteAddr(`PCOC_IDX_OUT)) begin
      outNext = pwdata[7:0] & `PCOC_OUT_MASK;
    end
    if (wrEn && paddr == byteAddr(`PCOC_IDX_USER)) begin
      userNext = pwdata[7:0] & `PCOC_USER_MASK;
    end
    updNext = wrEn && paddr == byteAddr(`PCOC_IDX_UPDATE) && pwdata[`PCOC_UPDATE_BIT];
  end

  // The calibrate bit is level storage only; the arm flag remembers its rise
  // so that a later update can still start the calibration.
  always_comb begin
    // RULE2 fire on update
    calStartNext = updReg && calArmedReg;
    calArmedNext = updReg ? 1'b0 : calArmedReg;
    // RULE2 arm on rise
    if (syncNext[`PCOC_CALIBRATE] && !syncReg[`PCOC_CALIBRATE]) begin
      calArmedNext = 1'b1;
    end
  end

  always_comb begin
    // RULE1 stall unmasked outputs
    stallANext  = syncNext[`PCOC_SOFT_SYNC] && !syncMaskA;
    stallBNext  = syncNext[`PCOC_SOFT_SYNC] && !syncMaskB;
    // RULE1 restart on clear
    restartNext = syncReg[`PCOC_SOFT_SYNC] && !syncNext[`PCOC_SOFT_SYNC];
    // RULE4 channel deep sleep
    sleepNext   = syncNext[`PCOC_CH_PWDN];
    // RULE5 driver only disable
    drvANext    = outNext[`PCOC_DIS_A] || outNext[`PCOC_PD_A];
    drvBNext    = outNext[`PCOC_DIS_B] || outNext[`PCOC_PD_B];
    // RULE6 divider and driver
    divANext    = outNext[`PCOC_PD_A];
    divBNext    = outNext[`PCOC_PD_B];
    // RULE7 manual reference select
    refNext     = userNext[`PCOC_REF_HI:`PCOC_REF_LO];
    // RULE8 RULE9 switching mode passed on
    swmNext     = userNext[`PCOC_SWM_HI:`PCOC_SWM_LO];
  end

  // Read data is captured in the setup cycle so it is stable for the access.
  always_comb begin
    rdataNext = rdataReg;
    errNext   = errReg;
    if (setup) begin
      errNext = 1'b0;
      unique case (paddr)
        byteAddr(`PCOC_IDX_SYNC):   rdataNext = {`PCOC_ZERO_PAD, syncReg};
        byteAddr(`PCOC_IDX_OUT):    rdataNext = {`PCOC_ZERO_PAD, outReg};
        byteAddr(`PCOC_IDX_USER):   rdataNext = {`PCOC_ZERO_PAD, userReg};
        // RULE13 history available readback
        byteAddr(`PCOC_IDX_STATUS): rdataNext = {31'h0000_0000, historyAvailable};
        byteAddr(`PCOC_IDX_UPDATE): rdataNext = 32'h0000_0000;
        default: begin
          rdataNext = 32'h0000_0000;
          errNext   = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncReg     <= `PCOC_REG_RESET;
      outReg      <= `PCOC_REG_RESET;
      userReg     <= `PCOC_REG_RESET;
      updReg      <= 1'b0;
      calArmedReg <= 1'b0;
      calStartReg <= 1'b0;
      restartReg  <= 1'b0;
      stallAReg   <= 1'b0;
      stallBReg   <= 1'b0;
      sleepReg    <= 1'b0;
      drvAReg     <= 1'b0;
      drvBReg     <= 1'b0;
      divAReg     <= 1'b0;
      divBReg     <= 1'b0;
      refReg      <= 2'b00;
      swmReg      <= 3'b000;
      loopReg     <= PCOC_LOOP_NORMAL;
      rdataReg    <= 32'h0000_0000;
      errReg      <= 1'b0;
      readyReg    <= 1'b0;
    end else begin
      syncReg     <= syncNext;
      outReg      <= outNext;
      userReg     <= userNext;
      updReg      <= updNext;
      calArmedReg <= calArmedNext;
      calStartReg <= calStartNext;
      restartReg  <= restartNext;
      stallAReg   <= stallANext;
      stallBReg   <= stallBNext;
      sleepReg    <= sleepNext;
      drvAReg     <= drvANext;
      drvBReg     <= drvBNext;
      divAReg     <= divANext;
      divBReg     <= divBNext;
      refReg      <= refNext;
      swmReg      <= swmNext;
      loopReg     <= modeBus.mode;
      rdataReg    <= rdataNext;
      errReg      <= errNext;
      readyReg    <= 1'b1;
    end
  end

  assign prdata      = rdataReg;
  assign pready      = readyReg;
  assign pslverr     = errReg;
  assign stallA      = stallAReg;
  assign stallB      = stallBReg;
  assign syncRestart = restartReg;
  assign calStart    = calStartReg;
  assign deepSleep   = sleepReg;
  assign driverOffA  = drvAReg;
  assign driverOffB  = drvBReg;
  assign dividerOffA = divAReg;
  assign dividerOffB = divBReg;
  assign refSelect   = refReg;
  assign switchMode  = swmReg;
  assign loopMode    = loopReg;

  //////////////////////////////////////////////////////////////////////////////

  property p_stall_follows;
    @(posedge clock) disable iff (rst)
      stallAReg == (syncReg[`PCOC_SOFT_SYNC] && !$past(syncMaskA));
  endproperty
  a_stall_follows: assert property (p_stall_follows) else $error("stall A wrong."); // RULE1

  property p_restart_pulse;
    @(posedge clock) disable iff (rst)
      $fell(syncReg[`PCOC_SOFT_SYNC]) |-> restartReg ##1 !restartReg;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("no restart."); // RULE1

  property p_cal_on_update;
    @(posedge clock) disable iff (rst)
      calStartReg |-> $past(updReg) && $past(calArmedReg);
  endproperty
  a_cal_on_update: assert property (p_cal_on_update) else $error("stray cal."); // RULE2

  property p_cal_fires;
    @(posedge clock) disable iff (rst)
      first_match($rose(syncReg[`PCOC_CALIBRATE]) ##[1:20] updReg) |=> calStartReg;
  endproperty
  a_cal_fires: assert property (p_cal_fires) else $error("cal missed."); // RULE2

  property p_sleep;
    @(posedge clock) disable iff (rst)
      deepSleep == syncReg[`PCOC_CH_PWDN];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep mismatch."); // RULE4

  property p_disable_only_driver;
    @(posedge clock) disable iff (rst)
      outReg[`PCOC_DIS_B] && !outReg[`PCOC_PD_B] |-> driverOffB && !dividerOffB;
  endproperty
  a_disable_only_driver: assert property (p_disable_only_driver) else $error("dis B."); // RULE5

  property p_powerdown_both;
    @(posedge clock) disable iff (rst)
      outReg[`PCOC_PD_A] |-> driverOffA && dividerOffA;
  endproperty
  a_powerdown_both: assert property (p_powerdown_both) else $error("pd A."); // RULE6

  property p_ref_and_mode;
    @(posedge clock) disable iff (rst)
      refSelect == userReg[`PCOC_REF_HI:`PCOC_REF_LO] &&
      switchMode == userReg[`PCOC_SWM_HI:`PCOC_SWM_LO];
  endproperty
  a_ref_and_mode: assert property (p_ref_and_mode) else $error("ref or mode."); // RULE7

  property p_holdover;
    @(posedge clock) disable iff (rst)
      userReg[`PCOC_USER_HOLD] && !userReg[`PCOC_USER_FREE] && $past(historyAvailable)
        |-> loopMode == PCOC_LOOP_HOLDOVER;
  endproperty
  a_holdover: assert property (p_holdover) else $error("no holdover."); // RULE11

  property p_no_history;
    @(posedge clock) disable iff (rst)
      userReg[`PCOC_USER_HOLD] && !$past(historyAvailable) |-> loopMode == PCOC_LOOP_FREERUN;
  endproperty
  a_no_history: assert property (p_no_history) else $error("no free run."); // RULE12

  property p_status_read;
    @(posedge clock) disable iff (rst)
      setup && paddr == byteAddr(`PCOC_IDX_STATUS) |=> prdata[0] == $past(historyAvailable);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bad."); // RULE13

  property p_freerun;
    @(posedge clock) disable iff (rst)
      userReg[`PCOC_USER_FREE] |-> loopMode == PCOC_LOOP_FREERUN;
  endproperty
  a_freerun: assert property (p_freerun) else $error("free run lost."); // RULE14

  property p_reserved_zero;
    @(posedge clock) disable iff (rst)
      (syncReg & ~`PCOC_SYNC_MASK) == 8'h00 && (outReg & ~`PCOC_OUT_MASK) == 8'h00 &&
      userReg[7] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set."); // RULE15

endmodule : pcoc_channel_ctrl

`default_nettype wire

// File: sim/tb_pll_channel_operational_controls.sv
// Self-checking bench for the channel operational control register bank.
// Assumes the design answers APB with zero wait states and checks its own timing.
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_params.svh"

module tb_pll_channel_operational_controls;
  import pcoc_pkg::*;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd = 32'h0000_701d;
  logic        pready, pslverr, syncMaskA = 0, syncMaskB = 0, historyAvailable = 0;
  logic        stallA, stallB, syncRestart, calStart, deepSleep;
  logic        driverOffA, driverOffB, dividerOffA, dividerOffB;
  logic [1:0]  refSelect;
  logic [2:0]  switchMode;
  pcoc_loop_t  loopMode;
  logic [33:0] expQ[$];
  logic [33:0] note;
  logic [2:0]  v, prev = 0;
  logic [6:0]  f;
  logic        armed = 0;
  int          failures = 0, comparisons = 0, calCount = 0, restartCount = 0;
  int          expCal = 0, expRestart = 0;

  always #4 clock = ~clock;

  pcoc_channel_ctrl dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .syncMaskA(syncMaskA), .syncMaskB(syncMaskB),
    .historyAvailable(historyAvailable), .stallA(stallA), .stallB(stallB),
    .syncRestart(syncRestart), .calStart(calStart), .deepSleep(deepSleep),
    .driverOffA(driverOffA), .driverOffB(driverOffB), .dividerOffA(dividerOffA),
    .dividerOffB(dividerOffB), .refSelect(refSelect), .switchMode(switchMode),
    .loopMode(loopMode));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext

  task automatic test_done;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: output got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge; after 20 edges without it, counts a failure and ends the test.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] expD, input logic expE);
    int n;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    expQ.push_back({wr, expE, expD});
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("ERROR %0t: no pready", $time);
      test_done();
    end else begin
      psel <= 0; penable <= 0;
    end
  endtask : apb

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    apb(1, {i, 2'b00}, d, 0, 0);
    #1;
  endtask : wr

  task automatic rd(input logic [13:0] i, input logic [31:0] e);
    apb(0, {i, 2'b00}, 0, e, 0);
  endtask : rd

  task automatic resetCheck;
    chk({stallA, stallB, deepSleep, driverOffA, driverOffB, dividerOffA, dividerOffB,
         refSelect, switchMode, loopMode}, 0);
    rd(`PCOC_IDX_SYNC, 0);
    rd(`PCOC_IDX_OUT, 0);
    rd(`PCOC_IDX_USER, 0);
    rd(`PCOC_IDX_UPDATE, 0);
    rd(`PCOC_IDX_STATUS, {31'b0, historyAvailable});
  endtask : resetCheck

  ////////////////////////////////////////////////////////////////////////////////
  // Results are compared against notes in issue order, so a lost answer shows.
  always @(posedge clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = expQ.pop_front();
      comparisons++;
      if (pslverr !== note[32] || (!note[33] && prdata !== note[31:0])) begin
        failures++;
        $display("ERROR %0t: bus answer %h err %b expected %h", $time, prdata, pslverr, note);
      end
    end
    if (calStart === 1'b1) calCount++;
    if (syncRestart === 1'b1) restartCount++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    resetCheck();
    for (int i = 0; i < 128; i++) begin
      @(posedge clock);
      rnd = lfsrNext(rnd);
      historyAvailable <= rnd[0];
      f = i[6:0];
      if (f[4:2] > 3'd4) f[4:2] = f[4:2] - 3'd4;
      wr(`PCOC_IDX_USER, {rnd[31:8], 1'b1, f});
      chk(refSelect, f[6:5]);
      chk(switchMode, f[4:2]);
      chk(loopMode, f[0] ? PCOC_LOOP_FREERUN : f[1] ? (rnd[0] ? PCOC_LOOP_HOLDOVER :
          PCOC_LOOP_FREERUN) : PCOC_LOOP_NORMAL);
      rd(`PCOC_IDX_USER, {25'b0, f});
      rd(`PCOC_IDX_STATUS, {31'b0, rnd[0]});
    end
    for (int i = 0; i < 16; i++) begin
      rnd = lfsrNext(rnd);
      wr(`PCOC_IDX_OUT, {rnd[31:4], i[3:0]});
      chk({driverOffB, driverOffA}, {i[3] | i[1], i[2] | i[0]});
      chk({dividerOffB, dividerOffA}, i[1:0]);
      rd(`PCOC_IDX_OUT, i[3:0]);
    end
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      rnd = lfsrNext(rnd);
      syncMaskA <= rnd[8];
      syncMaskB <= rnd[9];
      v = rnd[2:0];
      // bench writes random sync values; only a rise of the calibrate bit arms a start
      wr(`PCOC_IDX_SYNC, rnd);
      if (prev[2] && !v[2]) expRestart++;
      if (!prev[1] && v[1]) armed = 1;
      prev = v;
      chk(deepSleep, v[0]);
      chk({stallA, stallB}, {v[2] & !rnd[8], v[2] & !rnd[9]});
      rd(`PCOC_IDX_SYNC, v);
      if (rnd[10]) begin
        wr(`PCOC_IDX_UPDATE, 1);
        if (armed) expCal++;
        armed = 0;
      end
      repeat (3) @(posedge clock);
      chk(calCount, expCal);
      chk(restartCount, expRestart);
    end
    wr(`PCOC_IDX_STATUS, 32'h0000_00FF);
    rd(`PCOC_IDX_STATUS, {31'b0, historyAvailable});
    apb(1, {14'h0A23, 2'b00}, 32'h0000_00FF, 0, 1);
    apb(0, {14'h0A23, 2'b00}, 0, 0, 1);
    @(posedge clock);
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    #1;
    resetCheck();
    repeat (3) @(posedge clock);
    test_done();
  end
endmodule : tb_pll_channel_operational_controls

`default_nettype wire
